// File: design/autonomous_timing_threshold_regs.sv
// Rate, power-on delay and threshold registers with the autonomous sample sequencer
`timescale 1ns/1ps
module autonomous_timing_threshold_regs #(
  parameter int unsigned PERIOD_CYC [16] = autonomous_timing_pkg::PERIOD_CYC_DEF,
  parameter int unsigned DELAY_CYC  [16] = autonomous_timing_pkg::DELAY_CYC_DEF
) (
  input  wire logic                                       core_clk,
  input  wire logic                                       reset,
  input  wire logic [7:0]                                 reg_addr,
  input  wire logic [7:0]                                 reg_wdata,
  input  wire logic                                       reg_wr,
  input  wire logic                                       reg_rd,
  output logic [7:0]                                      reg_rdata,
  input  wire logic                                       auto_en,
  input  wire logic                                       data_twos_comp,
  input  wire logic                                       companion_enable_polarity,
  input  wire logic [2:0]                                 general_pin_zero_mode,
  input  wire logic [2:0]                                 general_pin_one_mode,
  input  wire logic [autonomous_timing_pkg::RESULT_W-1:0] result_data,
  input  wire logic                                       result_valid,
  input  wire logic                                       upper_alert_clr,
  input  wire logic                                       lower_alert_clr,
  output logic                                            sample_req,
  output logic                                            companion_enable_out,
  output logic                                            upper_threshold_irq,
  output logic                                            lower_threshold_irq,
  output logic                                            upper_alert_flag,
  output logic                                            lower_alert_flag
);
  import autonomous_timing_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]         rate_delay_r;
  logic [7:0]         rate_delay_nxt;
  logic [LIMIT_W-1:0] upper_limit_r;
  logic [LIMIT_W-1:0] upper_limit_nxt;
  logic [LIMIT_W-1:0] lower_limit_r;
  logic [LIMIT_W-1:0] lower_limit_nxt;
  logic [HYST_W-1:0]  upper_hyst_r;
  logic [HYST_W-1:0]  upper_hyst_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic [3:0]         rate_sel;
  logic [3:0]         delay_sel;

  assign rate_sel  = rate_delay_r[RATE_SEL_MSB:RATE_SEL_LSB];
  assign delay_sel = rate_delay_r[DELAY_SEL_MSB:DELAY_SEL_LSB];

  always_comb begin
    rate_delay_nxt  = rate_delay_r;
    upper_limit_nxt = upper_limit_r;
    lower_limit_nxt = lower_limit_r;
    upper_hyst_nxt  = upper_hyst_r;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_RATE_DELAY: rate_delay_nxt = reg_wdata;
        ADDR_UPPER_LO:   upper_limit_nxt[7:0] = reg_wdata;
        // Reserved top nibble is dropped on write
        ADDR_UPPER_HI:   upper_limit_nxt[LIMIT_W-1:8] = reg_wdata[LIMIT_HI_W-1:0];
        ADDR_LOWER_LO:   lower_limit_nxt[7:0] = reg_wdata;
        ADDR_LOWER_HI:   lower_limit_nxt[LIMIT_W-1:8] = reg_wdata[LIMIT_HI_W-1:0];
        ADDR_UPPER_HYST: upper_hyst_nxt = reg_wdata[HYST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RATE_DELAY: rdata_nxt = rate_delay_r;
        ADDR_UPPER_LO:   rdata_nxt = upper_limit_r[7:0];
        ADDR_UPPER_HI:   rdata_nxt = {4'h0, upper_limit_r[LIMIT_W-1:8]};
        ADDR_LOWER_LO:   rdata_nxt = lower_limit_r[7:0];
        ADDR_LOWER_HI:   rdata_nxt = {4'h0, lower_limit_r[LIMIT_W-1:8]};
        ADDR_UPPER_HYST: rdata_nxt = {1'b0, upper_hyst_r};
        default:         rdata_nxt = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rate_delay_r  <= RATE_DELAY_RST;
      upper_limit_r <= LIMIT_RST;
      lower_limit_r <= LIMIT_RST;
      upper_hyst_r  <= HYST_RST;
      rdata_r       <= UNMAPPED_READ;
    end else begin
      rate_delay_r  <= rate_delay_nxt;
      upper_limit_r <= upper_limit_nxt;
      lower_limit_r <= lower_limit_nxt;
      upper_hyst_r  <= upper_hyst_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************************************
  // Sample sequencer
  // ****************************************************************
  seq_state_t       state_r;
  seq_state_t       state_nxt;
  logic [CNT_W-1:0] period_cnt_r;
  logic [CNT_W-1:0] period_cnt_nxt;
  logic [CNT_W-1:0] delay_cnt_r;
  logic [CNT_W-1:0] delay_cnt_nxt;
  logic             enable_active_r;
  logic             enable_active_nxt;
  logic             pin_out_r;
  logic             pin_out_nxt;
  logic             sample_req_r;
  logic             sample_req_nxt;
  logic             routed;
  logic             tick;

  assign routed = (general_pin_zero_mode == PIN_MODE_COMPANION) ||
                  (general_pin_one_mode == PIN_MODE_COMPANION);
  assign tick   = auto_en && (period_cnt_r == '0);

  // Period counter runs regardless of the sequencer; a tick that lands while a
  // sample is still in progress is skipped so the rate never overlaps a conversion.
  always_comb begin
    period_cnt_nxt = period_cnt_r;
    if (!auto_en || period_cnt_r == '0) begin
      period_cnt_nxt = CNT_W'(PERIOD_CYC[rate_sel] - 1);
    end else begin
      period_cnt_nxt = period_cnt_r - 1'b1;
    end
  end

  always_comb begin
    state_nxt         = state_r;
    delay_cnt_nxt     = delay_cnt_r;
    enable_active_nxt = enable_active_r;
    sample_req_nxt    = 1'b0;
    unique case (state_r)
      SEQ_IDLE: begin
        if (tick) begin
          if (routed) begin
            state_nxt         = SEQ_POWER_ON;
            enable_active_nxt = 1'b1;
            delay_cnt_nxt     = CNT_W'(DELAY_CYC[delay_sel] - 1);
          end else begin
            state_nxt      = SEQ_CONVERT;
            sample_req_nxt = 1'b1;
          end
        end
      end
      SEQ_POWER_ON: begin
        if (delay_cnt_r == '0) begin
          state_nxt      = SEQ_CONVERT;
          sample_req_nxt = 1'b1;
        end else begin
          delay_cnt_nxt = delay_cnt_r - 1'b1;
        end
      end
      SEQ_CONVERT: begin
        // Amplifier stays powered until the result is in
        if (result_valid) begin
          state_nxt         = SEQ_IDLE;
          enable_active_nxt = 1'b0;
        end
      end
    endcase
    if (!auto_en) begin
      state_nxt         = SEQ_IDLE;
      enable_active_nxt = 1'b0;
      sample_req_nxt    = 1'b0;
    end
    pin_out_nxt = companion_enable_polarity ? enable_active_nxt : !enable_active_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r         <= SEQ_IDLE;
      period_cnt_r    <= '0;
      delay_cnt_r     <= '0;
      enable_active_r <= 1'b0;
      pin_out_r       <= 1'b0;
      sample_req_r    <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      period_cnt_r    <= period_cnt_nxt;
      delay_cnt_r     <= delay_cnt_nxt;
      enable_active_r <= enable_active_nxt;
      pin_out_r       <= pin_out_nxt;
      sample_req_r    <= sample_req_nxt;
    end
  end

  assign sample_req           = sample_req_r;
  assign companion_enable_out = pin_out_r;

  // ****************************************************************
  // Threshold detection
  // ****************************************************************
  logic above;
  logic below;
  logic upper_irq_r;
  logic upper_irq_nxt;
  logic lower_irq_r;
  logic lower_irq_nxt;
  logic upper_flag_r;
  logic upper_flag_nxt;
  logic lower_flag_r;
  logic lower_flag_nxt;
  logic judge;

  threshold_compare u_compare (
    .result      (result_data),
    .upper_limit (upper_limit_r),
    .lower_limit (lower_limit_r),
    .twos_comp   (data_twos_comp),
    .above       (above),
    .below       (below)
  );

  assign judge = result_valid && auto_en;

  always_comb begin
    upper_irq_nxt  = upper_irq_r;
    lower_irq_nxt  = lower_irq_r;
    if (judge) begin
      upper_irq_nxt = above;
      lower_irq_nxt = below;
    end
    // Set beats a clear arriving in the same cycle, so no event is lost
    upper_flag_nxt = (upper_flag_r && !upper_alert_clr) || (judge && above);
    lower_flag_nxt = (lower_flag_r && !lower_alert_clr) || (judge && below);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      upper_irq_r  <= 1'b0;
      lower_irq_r  <= 1'b0;
      upper_flag_r <= 1'b0;
      lower_flag_r <= 1'b0;
    end else begin
      upper_irq_r  <= upper_irq_nxt;
      lower_irq_r  <= lower_irq_nxt;
      upper_flag_r <= upper_flag_nxt;
      lower_flag_r <= lower_flag_nxt;
    end
  end

  assign upper_threshold_irq = upper_irq_r;
  assign lower_threshold_irq = lower_irq_r;
  assign upper_alert_flag    = upper_flag_r;
  assign lower_alert_flag    = lower_flag_r;

endmodule : autonomous_timing_threshold_regs

// File: design/autonomous_timing_pkg.sv
// Constants, register map and timing tables for the autonomous timing and threshold block
// What this block does
// - Four-bit field picks burst/autonomous sample rate, 2 MSPS down to 111 SPS; this block has no burst mode, only the autonomous sequencer uses it.
// - Programmable wait from companion enable assertion to sampling instant, 500 ns to 9 ms.
// - Enable-to-sample wait applies only when companion enable is routed to a pin.
// - Rate and delay register resets to zero: 2 MSPS, 500 ns.
// - Upper limit is 12 bits in [11:0]; bits [15:12] reserved, read-only.
// - Both limits use the same number format as conversion results.
// - Lower limit is 12 bits in [11:0] and is used in autonomous modes.
// - Both limit registers reset to zero; upper limit starts at byte 0x28.
// - Companion enable is active high when polarity is one, active low when zero.
// - Upper alert flag is sticky and clears only by writing one.
package autonomous_timing_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_RATE_DELAY  = 8'h27;
  localparam logic [7:0] ADDR_UPPER_LO    = 8'h28;
  localparam logic [7:0] ADDR_UPPER_HI    = 8'h29;
  localparam logic [7:0] ADDR_LOWER_LO    = 8'h2A;
  localparam logic [7:0] ADDR_LOWER_HI    = 8'h2B;
  localparam logic [7:0] ADDR_UPPER_HYST  = 8'h2C;

  localparam logic [7:0]  RATE_DELAY_RST  = 8'h00;
  localparam logic [11:0] LIMIT_RST       = 12'h000;
  localparam logic [6:0]  HYST_RST        = 7'h00;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  localparam int RATE_SEL_MSB   = 7;
  localparam int RATE_SEL_LSB   = 4;
  localparam int DELAY_SEL_MSB  = 3;
  localparam int DELAY_SEL_LSB  = 0;
  localparam int LIMIT_W        = 12;
  localparam int LIMIT_HI_W     = 4;
  localparam int HYST_W         = 7;
  localparam int RESULT_W       = 16;

  localparam logic [2:0] PIN_MODE_COMPANION = 3'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ  = 100_000_000;
  localparam int unsigned NS_PER_S_DIV_HZ_SCALE = 1000;
  localparam int CNT_W = 24;

  // Sample rates in tenths of a sample per second, so 33.3 kSPS stays exact
  localparam int unsigned RATE_X10 [16] = '{
    20000000, 10000000, 3000000, 1000000, 333000, 100000, 30000, 10000,
    5000, 3330, 2500, 2000, 1660, 1400, 1250, 1110};

  // Enable-to-sample delays in ns
  localparam int unsigned DELAY_NS [16] = '{
    500, 1000, 3300, 10000, 30000, 100000, 330000, 1000000,
    2000000, 3000000, 4000000, 5000000, 6000000, 7000000, 8000000, 9000000};

  function automatic int unsigned period_cyc(input int idx);
    return (CLK_HZ * 10) / RATE_X10[idx];
  endfunction : period_cyc

  // Least time: round up to whole cycles
  function automatic int unsigned delay_cyc(input int idx);
    return (DELAY_NS[idx] * (CLK_HZ / 1000000) + NS_PER_S_DIV_HZ_SCALE - 1) / NS_PER_S_DIV_HZ_SCALE;
  endfunction : delay_cyc

  localparam int unsigned PERIOD_CYC_DEF [16] = '{
    period_cyc(0), period_cyc(1), period_cyc(2), period_cyc(3),
    period_cyc(4), period_cyc(5), period_cyc(6), period_cyc(7),
    period_cyc(8), period_cyc(9), period_cyc(10), period_cyc(11),
    period_cyc(12), period_cyc(13), period_cyc(14), period_cyc(15)};

  localparam int unsigned DELAY_CYC_DEF [16] = '{
    delay_cyc(0), delay_cyc(1), delay_cyc(2), delay_cyc(3),
    delay_cyc(4), delay_cyc(5), delay_cyc(6), delay_cyc(7),
    delay_cyc(8), delay_cyc(9), delay_cyc(10), delay_cyc(11),
    delay_cyc(12), delay_cyc(13), delay_cyc(14), delay_cyc(15)};

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_POWER_ON,
    SEQ_CONVERT
  } seq_state_t;

endpackage : autonomous_timing_pkg

// File: design/threshold_compare.sv
// Window comparison of one conversion result against the two limits
`timescale 1ns/1ps
module threshold_compare (
  input  wire logic [autonomous_timing_pkg::RESULT_W-1:0] result,
  input  wire logic [autonomous_timing_pkg::LIMIT_W-1:0]  upper_limit,
  input  wire logic [autonomous_timing_pkg::LIMIT_W-1:0]  lower_limit,
  input  wire logic                                       twos_comp,
  output logic                                            above,
  output logic                                            below
);
  import autonomous_timing_pkg::*;

  // Flipping the sign bit maps two's complement onto an unsigned order
  function automatic logic [LIMIT_W-1:0] to_order(input logic [LIMIT_W-1:0] v, input logic tc);
    return {v[LIMIT_W-1] ^ tc, v[LIMIT_W-2:0]};
  endfunction : to_order

  logic [LIMIT_W-1:0] res_top;

  // Limits have 12 bits, so only the top 12 bits of the result take part
  assign res_top = result[RESULT_W-1:RESULT_W-LIMIT_W];

  always_comb begin
    above = to_order(res_top, twos_comp) > to_order(upper_limit, twos_comp);
    below = to_order(res_top, twos_comp) < to_order(lower_limit, twos_comp);
  end

endmodule : threshold_compare

// File: sim/autonomous_timing_asserts.sv
// Checker for the rate, delay and threshold register block
`timescale 1ns/1ps
module autonomous_timing_asserts (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       auto_en,
  input wire logic       result_valid,
  input wire logic       companion_enable_polarity,
  input wire logic       companion_enable_out,
  input wire logic       sample_req,
  input wire logic       upper_alert_clr,
  input wire logic       lower_alert_clr,
  input wire logic       upper_threshold_irq,
  input wire logic       lower_threshold_irq,
  input wire logic       upper_alert_flag,
  input wire logic       lower_alert_flag
);
  // ****************
  // Port relations
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_sample_single: assert property (sample_req |=> !sample_req)
    else $error("sampling pulse longer than one cycle");
  a_idle_quiet: assert property ((!auto_en) [*2] |=> !sample_req)
    else $error("sampling while stopped");
  a_upper_sets: assert property ($rose(upper_threshold_irq) |-> upper_alert_flag)
    else $error("upper flag not set with interrupt");
  a_upper_sticky: assert property (upper_alert_flag && !upper_alert_clr |=> upper_alert_flag)
    else $error("upper flag dropped without clear");
  a_lower_sticky: assert property (lower_alert_flag && !lower_alert_clr |=> lower_alert_flag)
    else $error("lower flag dropped without clear");
  a_upper_clear: assert property (upper_alert_clr && !result_valid |=> !upper_alert_flag)
    else $error("upper flag survived clear");
  a_irq_holds: assert property (!(result_valid && auto_en) |=>
    $stable(upper_threshold_irq) && $stable(lower_threshold_irq))
    else $error("interrupt moved without a result");
  a_enable_release: assert property (result_valid ##1 $stable(companion_enable_polarity) |->
    companion_enable_out != companion_enable_polarity)
    else $error("companion enable still active after result");
endmodule : autonomous_timing_asserts
bind autonomous_timing_threshold_regs autonomous_timing_asserts autonomous_timing_asserts_inst (
  .core_clk, .reset, .reg_rd, .reg_rdata, .auto_en, .result_valid, .companion_enable_polarity, .lower_alert_clr,
  .companion_enable_out, .sample_req, .upper_alert_clr, .upper_threshold_irq, .lower_threshold_irq,
  .upper_alert_flag, .lower_alert_flag);

// File: sim/conv_model.sv
// Converter stand-in that answers each sampling request with one result
`timescale 1ns/1ps
module conv_model #(
  parameter int LAT = 3
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        sample_req,
  input  wire logic [15:0] next_result,
  output logic             result_valid,
  output logic [15:0]      result_data
);
  // ****************
  // Conversion
  // ****************
  int cnt;
  // Data toggles outside the valid cycle so a stale read cannot match by luck
  always @(posedge core_clk) begin
    result_valid <= 1'b0;
    result_data  <= ~result_data;
    if (reset) begin
      cnt         <= 0;
      result_data <= 16'hA5A5;
    end else if (sample_req) begin
      cnt <= LAT;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    if (!reset && cnt == 1) begin
      result_valid <= 1'b1;
      result_data  <= next_result;
    end
  end
endmodule : conv_model

// File: sim/autonomous_timing_threshold_regs_tb.sv
// Self-checking bench for the rate, delay and threshold register block
`timescale 1ns/1ps
module autonomous_timing_threshold_regs_tb;
  import autonomous_timing_pkg::*;
  // ****************
  // Setup
  // ****************
  // Short counts keep the run brief; expectations come from these tables
  localparam int unsigned PER [16] = '{30, 33, 36, 39, 42, 45, 48, 51, 54, 57, 60, 63, 66, 69, 72, 75};
  localparam int unsigned DLY [16] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17};
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        reg_wr, reg_rd, auto_en, data_twos_comp, companion_enable_polarity;
  logic        upper_alert_clr, lower_alert_clr, result_valid, sample_req, companion_enable_out;
  logic        upper_threshold_irq, lower_threshold_irq, upper_alert_flag, lower_alert_flag;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  general_pin_zero_mode, general_pin_one_mode;
  logic [15:0] result_data, next_result;
  int          error_cnt = 0, n_checks = 0, cyc = 0;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  autonomous_timing_threshold_regs #(.PERIOD_CYC(PER), .DELAY_CYC(DLY)) autonomous_timing_threshold_regs_inst (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .auto_en, .data_twos_comp,
    .companion_enable_polarity, .general_pin_zero_mode, .general_pin_one_mode, .result_data, .result_valid,
    .upper_alert_clr, .lower_alert_clr, .sample_req, .companion_enable_out, .upper_threshold_irq,
    .lower_threshold_irq, .upper_alert_flag, .lower_alert_flag);
  conv_model conv_model_inst (.core_clk, .reset, .sample_req, .next_result, .result_valid, .result_data);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    reg_rd = 1'b0;
    check("register read", reg_rdata, e);
  endtask : rd_chk

  // Event 0 sampling pulse, 1 companion enable active, 2 result
  task automatic wait_ev(input int ev);
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (ev == 0 ? sample_req === 1'b1 : ev == 1 ? companion_enable_out === companion_enable_polarity
          : result_valid === 1'b1) return;
    end
    error_cnt++;
    $display("[FAIL] wait for event %0d expected 1 seen 0", ev);
    complete_run();
  endtask : wait_ev

  task automatic t_regs();
    logic [7:0] a [8] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h30, 8'h26};
    logic [7:0] d [8] = '{8'hA5, 8'h5A, 8'hFF, 8'hC3, 8'hFF, 8'hFF, 8'hFF, 8'h11};
    logic [7:0] e [8] = '{8'hA5, 8'h5A, 8'h0F, 8'hC3, 8'h0F, 8'h7F, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd_chk(a[i], 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(a[i], d[i]);
      rd_chk(a[i], e[i]);
    end
    $display("register test done");
  endtask : t_regs

  task automatic t_rates();
    int t0;
    for (int k = 0; k < 16; k++) begin
      auto_en = 1'b0;
      wr(ADDR_RATE_DELAY, 8'(k << 4));
      auto_en = 1'b1;
      wait_ev(0);
      t0 = cyc;
      check("enable unrouted", companion_enable_out, 16'h0000);
      wait_ev(0);
      check("sample period", 16'(cyc - t0), 16'(PER[k]));
    end
    $display("rate test done");
  endtask : t_rates

  task automatic t_delays();
    int t0;
    for (int k = 0; k < 16; k++) begin
      auto_en = 1'b0;
      companion_enable_polarity = k[0];
      general_pin_zero_mode = k[1] ? 3'h3 : 3'h1;
      general_pin_one_mode = k[1] ? 3'h0 : 3'h3;
      wr(ADDR_RATE_DELAY, {4'hF, 4'(k)});
      check("enable idle", companion_enable_out, 16'(!k[0]));
      auto_en = 1'b1;
      wait_ev(1);
      t0 = cyc;
      wait_ev(0);
      check("enable delay", 16'(cyc - t0), 16'(DLY[k]));
      check("enable held", companion_enable_out, 16'(k[0]));
    end
    $display("delay test done");
  endtask : t_delays

  task automatic judge(input logic [15:0] r, input logic up, input logic lo);
    next_result = r;
    wait_ev(2);
    @(negedge core_clk);
    check("upper irq", upper_threshold_irq, 16'(up));
    check("lower irq", lower_threshold_irq, 16'(lo));
  endtask : judge

  task automatic t_thresh();
    {auto_en, general_pin_zero_mode, general_pin_one_mode} = 7'h00;
    wr(ADDR_RATE_DELAY, 8'h00);
    wr(ADDR_UPPER_LO, 8'h00);
    wr(ADDR_UPPER_HI, 8'h08);
    wr(ADDR_LOWER_LO, 8'h10);
    wr(ADDR_LOWER_HI, 8'h00);
    auto_en = 1'b1;
    judge(16'h8010, 1'b1, 1'b0);
    judge(16'h8000, 1'b0, 1'b0);
    check("upper flag", upper_alert_flag, 16'h0001);
    judge(16'h00F0, 1'b0, 1'b1);
    judge(16'h0100, 1'b0, 1'b0);
    upper_alert_clr = 1'b1;
    @(negedge core_clk);
    upper_alert_clr = 1'b0;
    check("upper flag", upper_alert_flag, 16'h0000);
    check("lower flag", lower_alert_flag, 16'h0001);
    lower_alert_clr = 1'b1;
    @(negedge core_clk);
    lower_alert_clr = 1'b0;
    check("lower flag clear", lower_alert_flag, 16'h0000);
    // Signed limits: +256 and -256
    data_twos_comp = 1'b1;
    wr(ADDR_UPPER_LO, 8'h00);
    wr(ADDR_UPPER_HI, 8'h01);
    wr(ADDR_LOWER_LO, 8'h00);
    wr(ADDR_LOWER_HI, 8'h0F);
    judge(16'h8000, 1'b0, 1'b1);
    judge(16'h7FF0, 1'b1, 1'b0);
    // A clear landing on the judging edge of a new violation must lose
    next_result = 16'h7FF0;
    wait_ev(2);
    upper_alert_clr = 1'b1;
    @(negedge core_clk);
    upper_alert_clr = 1'b0;
    check("upper flag set wins", upper_alert_flag, 16'h0001);
    judge(16'hF100, 1'b0, 1'b0);
    auto_en = 1'b0;
    $display("threshold test done");
  endtask : t_thresh

  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, auto_en, data_twos_comp} = 20'h00000;
    {general_pin_zero_mode, general_pin_one_mode, upper_alert_clr, lower_alert_clr} = 8'h00;
    companion_enable_polarity = 1'b1;
    next_result = 16'h0000;
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    t_regs();
    t_rates();
    t_delays();
    t_thresh();
    complete_run();
  end
endmodule : autonomous_timing_threshold_regs_tb
